//--- logic/pcg_consts.svh
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// register offsets from the system control base
`define PCG_BASE_ADDR 32'h400FE000
`define PCG_OFF_RUN_GATE 12'h104
`define PCG_OFF_SLEEP_GATE 12'h114
`define PCG_OFF_DEEP_GATE 12'h124
`define PCG_OFF_RUN_CLOCK_CONFIG 12'h060
`define PCG_OFF_IRQ_STATUS 12'h150
`define PCG_OFF_IRQ_MASK 12'h154

// field positions
`define PCG_BIT_ASYNC_SERIAL_0 0
`define PCG_BIT_ASYNC_SERIAL_1 1
`define PCG_BIT_SYNC_SERIAL_0 4
`define PCG_BIT_COUNTER_UNIT_0 16
`define PCG_BIT_COUNTER_UNIT_1 17
`define PCG_BIT_COUNTER_UNIT_2 18
`define PCG_BIT_COMPARATOR_0 24
`define PCG_BIT_COMPARATOR_1 25
`define PCG_BIT_COMPARATOR_2 26
`define PCG_BIT_AUTO_GATING 0
`define PCG_BIT_IRQ_FAULT 0
`define PCG_BIT_IRQ_UNMAPPED 1

// writable masks and reset values
`define PCG_MASK_RUN_GATE 32'h00070013
`define PCG_MASK_SLEEP_GATE 32'h07070013
`define PCG_MASK_RUN_CLOCK_CONFIG 32'h00000001
`define PCG_MASK_IRQ 32'h00000003
`define PCG_RESET_GATE 32'h00000000
`define PCG_RESET_CONFIG 32'h00000000
`define PCG_RESET_IRQ 32'h00000000

// gated units
`define PCG_NUM_UNITS 9
`define PCG_ADDR_W 12

`endif

//--- logic/pcg_pkg.sv
`default_nettype none
`include "pcg_consts.svh"
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_RUN,
    PCG_SLEEP,
    PCG_DEEP
  } pcg_mode_t;

  // unit vector order: async_serial_0_gate, async_serial_1_gate, sync_serial_0_gate, counter_unit_0_gate..2, comparator0..2
  typedef logic [`PCG_NUM_UNITS-1:0] pcg_units_t;
  typedef logic [31:0] pcg_word_t;
  typedef logic [`PCG_ADDR_W-1:0] pcg_addr_t;
endpackage : pcg_pkg
`default_nettype wire

//--- logic/pcg_gate_if.sv
`default_nettype none
interface pcg_gate_if;
  import pcg_pkg::*;
  pcg_units_t en;
  pcg_units_t gclk;
  modport ctrl (output en, input gclk);
  modport gate (input en, output gclk);
endinterface : pcg_gate_if
`default_nettype wire

//--- logic/pcg_clock_gate.sv
`default_nettype none
`include "pcg_consts.svh"
module pcg_clock_gate
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // enables in, gated clocks out
  pcg_gate_if.gate g
);
  pcg_units_t en_lo_reg;
  pcg_units_t en_lo_next;

  always_comb
  begin
    en_lo_next = g.en;
  end

  // enable moves on the falling edge, so only while mclk is low
  always_ff @(negedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      en_lo_reg <= '0;
    else
      en_lo_reg <= en_lo_next;
  end

  assign g.gclk = {`PCG_NUM_UNITS{mclk}} & en_lo_reg;
endmodule : pcg_clock_gate
`default_nettype wire

//--- logic/pcg_top.sv
// Function
// - A set gating bit clocks its peripheral; a clear bit stops its clock.
// - An access to a peripheral whose clock is gated off ends in a bus fault.
// - Every gating bit reads 0 after reset, so all peripherals are unclocked.
// - Run, sleep and deep-sleep registers apply in their own power state.
// - Sleep and deep-sleep registers apply only with automatic gating set; sleep comparator bits 26:24 apply in every state but auto-gated deep sleep.
// - Bits 18, 17 and 16 enable counter units 2, 1 and 0.
// - Bit 4 enables sync serial 0; bits 1 and 0 enable async serial 1 and 0.
// - Sleep register bits 26, 25 and 24 enable comparators 2, 1 and 0.
// - Reserved bits read 0 and ignore writes; software preserves them.
// - Run register sits at 0x104 and sleep register at 0x114.
// - Deep-sleep register sits at 0x124 with the sleep register layout.
//
// Local design decision: the address-and-strobe port.
`default_nettype none
`include "pcg_consts.svh"
module pcg_top
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [`PCG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // power state from the core
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  // peripheral access check
  input wire logic periph_access,
  input wire logic [3:0] periph_target,
  output logic periph_fault,
  output logic periph_ok,
  // peripheral clocks
  output logic [`PCG_NUM_UNITS-1:0] periph_clk_en,
  output logic [`PCG_NUM_UNITS-1:0] periph_gclk,
  // interrupt
  output logic irq
);

  function automatic logic hit(input pcg_addr_t a, input pcg_addr_t off);
    hit = (a == off);
  endfunction : hit

  // maps a register image to the unit vector
  function automatic pcg_units_t to_units(input pcg_word_t r,
                                          input logic with_comp);
    pcg_units_t u;
    u = '0;
    u[0] = r[`PCG_BIT_ASYNC_SERIAL_0];
    u[1] = r[`PCG_BIT_ASYNC_SERIAL_1];
    u[2] = r[`PCG_BIT_SYNC_SERIAL_0];
    u[3] = r[`PCG_BIT_COUNTER_UNIT_0];
    u[4] = r[`PCG_BIT_COUNTER_UNIT_1];
    u[5] = r[`PCG_BIT_COUNTER_UNIT_2];
    if (with_comp)
    begin
      u[6] = r[`PCG_BIT_COMPARATOR_0];
      u[7] = r[`PCG_BIT_COMPARATOR_1];
      u[8] = r[`PCG_BIT_COMPARATOR_2];
    end
    to_units = u;
  endfunction : to_units

  function automatic pcg_word_t w1c(input pcg_word_t cur,
                                    input pcg_word_t clr,
                                    input pcg_word_t set);
    // set wins over a clear in the same cycle
    w1c = ((cur & ~clr) | set) & `PCG_MASK_IRQ;
  endfunction : w1c

  pcg_gate_if gif ();

  // register file
  pcg_word_t run_gate_enables_reg;
  pcg_word_t run_gate_enables_next;
  pcg_word_t sleep_gate_enables_reg;
  pcg_word_t sleep_gate_enables_next;
  pcg_word_t deep_sleep_gate_enables_reg;
  pcg_word_t deep_sleep_gate_enables_next;
  pcg_word_t run_clock_config_reg;
  pcg_word_t run_clock_config_next;
  pcg_word_t irq_status_reg;
  pcg_word_t irq_status_next;
  pcg_word_t irq_mask_reg;
  pcg_word_t irq_mask_next;
  pcg_word_t rdata_reg;
  pcg_word_t rdata_next;
  logic mapped;
  logic unmapped_event;
  pcg_word_t set_bits;
  logic auto_gating_select;
  logic fault_event;

  always_comb
  begin
    mapped = hit(reg_addr, `PCG_OFF_RUN_GATE)
      || hit(reg_addr, `PCG_OFF_SLEEP_GATE)
      || hit(reg_addr, `PCG_OFF_DEEP_GATE)
      || hit(reg_addr, `PCG_OFF_RUN_CLOCK_CONFIG)
      || hit(reg_addr, `PCG_OFF_IRQ_STATUS)
      || hit(reg_addr, `PCG_OFF_IRQ_MASK);
    unmapped_event = (reg_wr || reg_rd) && !mapped;
    set_bits = '0;
    set_bits[`PCG_BIT_IRQ_FAULT] = fault_event;
    set_bits[`PCG_BIT_IRQ_UNMAPPED] = unmapped_event;
    run_gate_enables_next = run_gate_enables_reg;
    sleep_gate_enables_next = sleep_gate_enables_reg;
    deep_sleep_gate_enables_next = deep_sleep_gate_enables_reg;
    run_clock_config_next = run_clock_config_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = w1c(irq_status_reg, '0, set_bits);
    if (reg_wr)
    begin
      // reserved bits are masked off on every write
      if (hit(reg_addr, `PCG_OFF_RUN_GATE))
        run_gate_enables_next = reg_wdata & `PCG_MASK_RUN_GATE;
      if (hit(reg_addr, `PCG_OFF_SLEEP_GATE))
        sleep_gate_enables_next = reg_wdata & `PCG_MASK_SLEEP_GATE;
      if (hit(reg_addr, `PCG_OFF_DEEP_GATE))
        deep_sleep_gate_enables_next = reg_wdata & `PCG_MASK_SLEEP_GATE;
      if (hit(reg_addr, `PCG_OFF_RUN_CLOCK_CONFIG))
        run_clock_config_next = reg_wdata & `PCG_MASK_RUN_CLOCK_CONFIG;
      if (hit(reg_addr, `PCG_OFF_IRQ_MASK))
        irq_mask_next = reg_wdata & `PCG_MASK_IRQ;
      if (hit(reg_addr, `PCG_OFF_IRQ_STATUS))
        irq_status_next = w1c(irq_status_reg, reg_wdata, set_bits);
    end
    rdata_next = '0;
    if (reg_rd)
    begin
      if (hit(reg_addr, `PCG_OFF_RUN_GATE))
        rdata_next = run_gate_enables_reg;
      else if (hit(reg_addr, `PCG_OFF_SLEEP_GATE))
        rdata_next = sleep_gate_enables_reg;
      else if (hit(reg_addr, `PCG_OFF_DEEP_GATE))
        rdata_next = deep_sleep_gate_enables_reg;
      else if (hit(reg_addr, `PCG_OFF_RUN_CLOCK_CONFIG))
        rdata_next = run_clock_config_reg;
      else if (hit(reg_addr, `PCG_OFF_IRQ_STATUS))
        rdata_next = irq_status_reg;
      else if (hit(reg_addr, `PCG_OFF_IRQ_MASK))
        rdata_next = irq_mask_reg;
      else
        rdata_next = '0;
    end
    auto_gating_select = run_clock_config_reg[`PCG_BIT_AUTO_GATING];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_gate_enables_reg <= `PCG_RESET_GATE;
      sleep_gate_enables_reg <= `PCG_RESET_GATE;
      deep_sleep_gate_enables_reg <= `PCG_RESET_GATE;
      run_clock_config_reg <= `PCG_RESET_CONFIG;
      irq_status_reg <= `PCG_RESET_IRQ;
      irq_mask_reg <= `PCG_RESET_IRQ;
      rdata_reg <= '0;
    end
    else
    begin
      run_gate_enables_reg <= run_gate_enables_next;
      sleep_gate_enables_reg <= sleep_gate_enables_next;
      deep_sleep_gate_enables_reg <= deep_sleep_gate_enables_next;
      run_clock_config_reg <= run_clock_config_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // power state tracking
  pcg_mode_t mode_reg;
  pcg_mode_t mode_next;

  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      PCG_RUN:
      begin
        if (deep_sleep_mode)
          mode_next = PCG_DEEP;
        else if (sleep_mode)
          mode_next = PCG_SLEEP;
      end
      PCG_SLEEP:
      begin
        if (deep_sleep_mode)
          mode_next = PCG_DEEP;
        else if (!sleep_mode)
          mode_next = PCG_RUN;
      end
      PCG_DEEP:
      begin
        if (!deep_sleep_mode)
          mode_next = sleep_mode ? PCG_SLEEP : PCG_RUN;
      end
      default:
        mode_next = PCG_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= PCG_RUN;
    else
      mode_reg <= mode_next;
  end

  // effective enables
  pcg_units_t en_reg;
  pcg_units_t en_next;
  pcg_units_t run_units;
  pcg_units_t sleep_units;

  always_comb
  begin
    // comparators have no run bit; in run they follow the sleep map
    sleep_units = to_units(sleep_gate_enables_reg, 1'b1);
    run_units = to_units(run_gate_enables_reg, 1'b0);
    run_units[8:6] = sleep_units[8:6];
    en_next = run_units;
    if (auto_gating_select)
    begin
      case (mode_reg)
        PCG_SLEEP:
          en_next = to_units(sleep_gate_enables_reg, 1'b1);
        PCG_DEEP:
          en_next = to_units(deep_sleep_gate_enables_reg, 1'b1);
        default:
          en_next = run_units;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      en_reg <= '0;
    else
      en_reg <= en_next;
  end

  assign gif.en = en_reg;

  pcg_clock_gate u_gate (
    .mclk (mclk),
    .rst_n (rst_n),
    .g (gif.gate)
  );

  // access check against the enables in force
  logic fault_reg;
  logic fault_next;
  logic ok_reg;
  logic ok_next;
  logic target_on;

  always_comb
  begin
    // unknown targets fault as well, nothing answers for them
    target_on = 1'b0;
    if (periph_target < 4'(`PCG_NUM_UNITS))
      target_on = en_reg[periph_target];
    fault_event = periph_access && !target_on;
    fault_next = fault_event;
    ok_next = periph_access && target_on;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_reg <= 1'b0;
      ok_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= fault_next;
      ok_reg <= ok_next;
    end
  end

  // interrupt
  logic irq_reg;
  logic irq_next;

  always_comb
  begin
    irq_next = |(irq_status_next & irq_mask_next);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  assign reg_rdata = rdata_reg;
  assign periph_fault = fault_reg;
  assign periph_ok = ok_reg;
  assign periph_clk_en = en_reg;
  // gated clocks come from the gate cells, not a flop, by nature
  assign periph_gclk = gif.gclk;
  assign irq = irq_reg;
endmodule : pcg_top
`default_nettype wire

//--- tb/pcg_monitor.sv
`default_nettype none
`include "pcg_consts.svh"
module pcg_monitor
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [`PCG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // power state and access check
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  input wire logic periph_access,
  input wire logic [3:0] periph_target,
  input wire logic periph_fault,
  input wire logic periph_ok,
  // clocks and interrupt
  input wire logic [`PCG_NUM_UNITS-1:0] periph_clk_en,
  input wire logic [`PCG_NUM_UNITS-1:0] periph_gclk,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_run_wr;
    reg_wr && reg_addr == `PCG_OFF_RUN_GATE && !sleep_mode && !deep_sleep_mode;
  endsequence
  sequence s_calm;
    !reg_wr && !sleep_mode && !deep_sleep_mode;
  endsequence
  a_run_map: assert property (s_run_wr ##1 s_calm |=>
    periph_clk_en[5:0] == {$past(reg_wdata[18:16], 2), $past(reg_wdata[4], 2),
    $past(reg_wdata[1:0], 2)}) else $error("run enables off map");
  a_fault_gated: assert property (periph_access &&
    periph_target < 4'h9 && !periph_clk_en[periph_target]
    |=> periph_fault && !periph_ok)
    else $error("gated access not faulted");
  a_ok_clocked: assert property (periph_access &&
    periph_target < 4'h9 && periph_clk_en[periph_target]
    |=> periph_ok && !periph_fault)
    else $error("clocked access not answered");
  a_bad_target: assert property (periph_access && periph_target >= 4'h9
    |=> periph_fault) else $error("unknown unit not faulted");
  // sampled on the falling edge, where the gated clock shows its latch
  a_gclk_follow: assert property (@(negedge mclk) disable iff (!rst_n)
    periph_gclk == $past(periph_clk_en)) else $error("gated clock mismatch");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {`PCG_OFF_RUN_GATE, `PCG_OFF_SLEEP_GATE, `PCG_OFF_DEEP_GATE,
    `PCG_OFF_RUN_CLOCK_CONFIG, `PCG_OFF_IRQ_STATUS, `PCG_OFF_IRQ_MASK})
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_reserved_zero: assert property (reg_rd &&
    reg_addr == `PCG_OFF_RUN_GATE
    |=> (reg_rdata & ~`PCG_MASK_RUN_GATE) == 32'h0)
    else $error("reserved bits not zero");
  a_reset_off: assert property ($rose(rst_n) |->
    periph_clk_en == '0 && !irq) else $error("units clocked after reset");
endmodule : pcg_monitor
bind pcg_top pcg_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .deep_sleep_mode(deep_sleep_mode), .periph_access(periph_access),
  .periph_target(periph_target), .periph_fault(periph_fault),
  .periph_ok(periph_ok), .periph_clk_en(periph_clk_en),
  .periph_gclk(periph_gclk), .irq(irq));
`default_nettype wire

//--- tb/pcg_periph_model.sv
`default_nettype none
`include "pcg_consts.svh"
module pcg_periph_model
  import pcg_pkg::*;
(
  // gated clocks in
  input wire logic [`PCG_NUM_UNITS-1:0] periph_gclk,
  input wire logic clear,
  // pulses seen by each unit
  output wire logic [`PCG_NUM_UNITS-1:0][7:0] pulse_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // a unit only advances on its own clock, so runt pulses would show here
  for (genvar i = 0; i < `PCG_NUM_UNITS; i++)
  begin : g_unit
    logic [7:0] cnt;
    always @(posedge periph_gclk[i] or posedge clear)
      if (clear)
        cnt <= 8'h00;
      else
        cnt <= cnt + 8'h01;
    assign pulse_cnt[i] = cnt;
  end
endmodule : pcg_periph_model
`default_nettype wire

//--- tb/pcg_top_bench.sv
`default_nettype none
`include "pcg_consts.svh"
module pcg_top_bench
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, reg_wr, reg_rd, sleep_mode, deep_sleep_mode, clear;
  logic periph_access, periph_fault, periph_ok, irq;
  logic [3:0] periph_target;
  pcg_addr_t reg_addr;
  pcg_word_t reg_wdata, reg_rdata;
  pcg_units_t periph_clk_en, periph_gclk;
  logic [`PCG_NUM_UNITS-1:0][7:0] pulse_cnt;
  int n_mismatch, n_compared;
  int pos [9] = '{0, 1, 4, 16, 17, 18, 24, 25, 26};
  pcg_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode), .periph_access(periph_access),
    .periph_target(periph_target), .periph_fault(periph_fault),
    .periph_ok(periph_ok), .periph_clk_en(periph_clk_en),
    .periph_gclk(periph_gclk), .irq(irq));
  pcg_periph_model i_model (.periph_gclk(periph_gclk), .clear(clear),
    .pulse_cnt(pulse_cnt));
  task automatic chk(input pcg_word_t got, input pcg_word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input pcg_addr_t a, input pcg_word_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input pcg_addr_t a, input pcg_word_t e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic acc(input logic [3:0] t, input logic ok);
    @(posedge mclk);
    periph_access <= 1'b1;
    periph_target <= t;
    @(posedge mclk);
    periph_access <= 1'b0;
    @(negedge mclk);
    chk(32'({periph_ok, periph_fault}), 32'({ok, ~ok}));
  endtask : acc
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // the whole run needs well under a thousand cycles
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, sleep_mode, deep_sleep_mode} = '0;
    {periph_access, periph_target, reg_addr, reg_wdata, clear} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`PCG_OFF_RUN_GATE, 32'h0);
    rd(`PCG_OFF_SLEEP_GATE, 32'h0);
    rd(`PCG_OFF_DEEP_GATE, 32'h0);
    chk(32'(periph_clk_en), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      wr(i < 6 ? `PCG_OFF_RUN_GATE : `PCG_OFF_SLEEP_GATE, 32'h1 << pos[i]);
      settle();
      chk(32'(periph_clk_en), 32'h1 << i);
      @(posedge mclk);
      clear <= 1'b1;
      @(posedge mclk);
      clear <= 1'b0;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      chk(32'(pulse_cnt[i]), 32'h8);
      chk(32'(pulse_cnt[(i + 1) % 9]), 32'h0);
      wr(i < 6 ? `PCG_OFF_RUN_GATE : `PCG_OFF_SLEEP_GATE, 32'h0);
    end
    $display("test bit map done");
    wr(`PCG_OFF_RUN_GATE, 32'hFFFFFFFF);
    rd(`PCG_OFF_RUN_GATE, `PCG_MASK_RUN_GATE);
    wr(`PCG_OFF_SLEEP_GATE, 32'hFFFFFFFF);
    rd(`PCG_OFF_SLEEP_GATE, `PCG_MASK_SLEEP_GATE);
    wr(`PCG_OFF_DEEP_GATE, 32'hFFFFFFFF);
    rd(`PCG_OFF_DEEP_GATE, `PCG_MASK_SLEEP_GATE);
    chk(32'(periph_clk_en), 32'h1FF);
    $display("test reserved done");
    wr(`PCG_OFF_RUN_GATE, 32'h1);
    wr(`PCG_OFF_SLEEP_GATE, 32'h2);
    wr(`PCG_OFF_DEEP_GATE, 32'h10);
    sleep_mode <= 1'b1;
    settle();
    chk(32'(periph_clk_en), 32'h1);
    wr(`PCG_OFF_RUN_CLOCK_CONFIG, 32'h1);
    settle();
    chk(32'(periph_clk_en), 32'h2);
    deep_sleep_mode <= 1'b1;
    settle();
    chk(32'(periph_clk_en), 32'h4);
    {sleep_mode, deep_sleep_mode} <= 2'b00;
    settle();
    chk(32'(periph_clk_en), 32'h1);
    $display("test modes done");
    for (int t = 0; t < 10; t++)
      acc(4'(t), t == 0);
    $display("test access done");
    wr(`PCG_OFF_IRQ_STATUS, 32'h3);
    wr(`PCG_OFF_IRQ_MASK, 32'h1);
    acc(4'h5, 1'b0);
    @(negedge mclk);
    chk(32'(irq), 32'h1);
    rd(`PCG_OFF_IRQ_STATUS, 32'h1);
    wr(`PCG_OFF_IRQ_STATUS, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    rd(12'h200, 32'h0);
    rd(`PCG_OFF_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    wr(`PCG_OFF_IRQ_MASK, 32'h3);
    settle();
    chk(32'(irq), 32'h1);
    wr(`PCG_OFF_IRQ_STATUS, 32'h2);
    settle();
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    summarize();
  end
endmodule : pcg_top_bench
`default_nettype wire
